// ==== rtl/pmbus_cmd_pkg.sv ====
// Command codes, field layouts and reset values for the PMBus command layer
package pmbus_cmd_pkg;

  localparam logic [7:0]  CMD_PAGE          = 8'h00;
  localparam logic [7:0]  CMD_OPERATION     = 8'h01;
  localparam logic [7:0]  CMD_ON_OFF_CONFIG = 8'h02;
  localparam logic [7:0]  CMD_WRITE_PROTECT = 8'h10;
  localparam logic [7:0]  CMD_CHAN_CFG      = 8'hD0;
  localparam logic [7:0]  CMD_COMMON_CFG    = 8'hD1;
  localparam logic [7:0]  CMD_CHAN_CFG2     = 8'hD9;
  localparam logic [7:0]  CMD_CHAN_CFG3     = 8'hDA;
  localparam logic [7:0]  CMD_GLOBAL_MASK   = 8'hE4;
  localparam logic [7:0]  CMD_ADDR_BASE     = 8'hE6;

  localparam logic [7:0]  PAGE_GLOBAL       = 8'hFF;

  localparam logic [7:0]  RST_PAGE          = 8'h00;
  localparam logic [7:0]  RST_OPERATION     = 8'h00;
  localparam logic [7:0]  RST_ON_OFF_CONFIG = 8'h12;
  localparam logic [7:0]  RST_WRITE_PROTECT = 8'h00;
  localparam logic [15:0] RST_CHAN_CFG      = 16'h0080;
  localparam logic [15:0] RST_COMMON_CFG    = 16'h0F7B;
  localparam logic [7:0]  RST_CHAN_CFG2     = 8'h00;
  localparam logic [7:0]  RST_CHAN_CFG3     = 8'h00;
  localparam logic [7:0]  RST_GLOBAL_MASK   = 8'h0F;
  localparam logic [7:0]  RST_ADDR_BASE     = 8'h5C;

  localparam logic [7:0]  WP_CODE_NONE      = 8'h00;
  localparam logic [7:0]  WP_CODE_LEVEL2    = 8'h40;
  localparam logic [7:0]  WP_CODE_LEVEL1    = 8'h80;

  // Gray order along rising strictness, so a numeric compare picks the stricter
  typedef enum logic [1:0] {
    PROT_NONE = 2'b00,
    PROT_L2   = 2'b01,
    PROT_L1   = 2'b11
  } prot_e;

  localparam int          OP_CTRL_LSB       = 6;
  localparam int          OP_MARGIN_LSB     = 4;
  localparam int          OP_FAULT_LSB      = 2;
  localparam logic [7:0]  OP_WMASK          = 8'hFC;
  localparam logic [1:0]  CTRL_OFF_NOW      = 2'b00;
  localparam logic [1:0]  CTRL_SEQ_OFF      = 2'b01;
  localparam logic [1:0]  CTRL_SEQ_ON       = 2'b10;
  localparam logic [1:0]  MARGIN_NOMINAL    = 2'b00;
  localparam logic [1:0]  MARGIN_LOW        = 2'b01;
  localparam logic [1:0]  MARGIN_HIGH       = 2'b10;
  localparam logic [1:0]  FAULT_IGNORE      = 2'b01;
  localparam logic [1:0]  FAULT_HONOR       = 2'b10;

  localparam int          ONOFF_USE_BUS_BIT = 3;
  localparam int          ONOFF_CTL_ON_BIT  = 4;
  localparam logic [7:0]  ONOFF_WMASK       = 8'h1D;
  localparam logic [7:0]  ONOFF_FORCE_ONE   = 8'h02;
  localparam logic [15:0] CHAN_CFG_WMASK    = 16'h7CFF;
  localparam logic [7:0]  MASK_WMASK        = 8'h0F;
  localparam logic [7:0]  ADDR_BASE_WMASK   = 8'h7F;
  localparam logic [3:0]  ADDR_OFFSET_MAX   = 4'h9;

endpackage

// ==== rtl/chan_ctl_if.sv ====
// Per-channel write strobes and readback between command decoder and channel slice
`timescale 1ns/1ps
interface chan_ctl_if;
  logic        wr_op;
  logic        wr_onoff;
  logic        wr_cfg;
  logic [15:0] wdata;
  logic [7:0]  op_rd;
  logic [7:0]  onoff_rd;
  logic [15:0] cfg_rd;
  logic        run;
  logic [1:0]  margin;
  logic        ignore_faults;
  logic        soft_off;
  logic        op_rejected;

  modport ctl  (output wr_op, wr_onoff, wr_cfg, wdata,
                input  op_rd, onoff_rd, cfg_rd, run, margin, ignore_faults, soft_off,
                       op_rejected);
  modport chan (input  wr_op, wr_onoff, wr_cfg, wdata,
                output op_rd, onoff_rd, cfg_rd, run, margin, ignore_faults, soft_off,
                       op_rejected);
endinterface // chan_ctl_if

// ==== rtl/pmbus_channel_slice.sv ====
// One channel: OPERATION, on/off config and channel config word with on/margin decode
`timescale 1ns/1ps
module pmbus_channel_slice
  import pmbus_cmd_pkg::*;
(
  input  wire logic   core_clk,
  input  wire logic   reset,
  chan_ctl_if.chan    cc
);

  logic [7:0]  op_ff,    nxt_op;
  logic [7:0]  onoff_ff, nxt_onoff;
  logic [15:0] cfg_ff,   nxt_cfg;
  logic        run_ff,   nxt_run;
  logic        soft_ff,  nxt_soft;
  logic        op_valid;
  logic [1:0]  w_ctrl, w_margin, w_fault;

  assign w_ctrl   = cc.wdata[OP_CTRL_LSB+1:OP_CTRL_LSB];
  assign w_margin = cc.wdata[OP_MARGIN_LSB+1:OP_MARGIN_LSB];
  assign w_fault  = cc.wdata[OP_FAULT_LSB+1:OP_FAULT_LSB];

  always_comb begin
    // Fault field is only checked for validity when margining away from nominal
    op_valid = (w_ctrl == CTRL_OFF_NOW) ||
               (((w_ctrl == CTRL_SEQ_ON) || (w_ctrl == CTRL_SEQ_OFF)) &&
                ((w_margin == MARGIN_NOMINAL) ||
                 (((w_margin == MARGIN_LOW) || (w_margin == MARGIN_HIGH)) &&
                  ((w_fault == FAULT_IGNORE) || (w_fault == FAULT_HONOR)))));
    nxt_op    = op_ff;
    nxt_onoff = onoff_ff;
    nxt_cfg   = cfg_ff;
    nxt_run   = run_ff;
    nxt_soft  = soft_ff;
    if (cc.wr_op && op_valid) begin
      nxt_op = cc.wdata[7:0] & OP_WMASK;
      if (onoff_ff[ONOFF_USE_BUS_BIT]) begin
        nxt_run  = (w_ctrl == CTRL_SEQ_ON);
        nxt_soft = (w_ctrl == CTRL_SEQ_OFF);
      end
    end
    if (cc.wr_onoff) begin
      nxt_onoff = (cc.wdata[7:0] & ONOFF_WMASK) | ONOFF_FORCE_ONE;
    end
    if (cc.wr_cfg) begin
      nxt_cfg = cc.wdata & CHAN_CFG_WMASK;
    end
    // Without bus control the channel follows its autonomous power-up choice
    if (!nxt_onoff[ONOFF_USE_BUS_BIT]) begin
      nxt_run  = !nxt_onoff[ONOFF_CTL_ON_BIT];
      nxt_soft = 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      op_ff    <= RST_OPERATION;
      onoff_ff <= RST_ON_OFF_CONFIG;
      cfg_ff   <= RST_CHAN_CFG;
      run_ff   <= 1'b0;
      soft_ff  <= 1'b0;
    end else begin
      op_ff    <= nxt_op;
      onoff_ff <= nxt_onoff;
      cfg_ff   <= nxt_cfg;
      run_ff   <= nxt_run;
      soft_ff  <= nxt_soft;
    end
  end

  assign cc.op_rd         = op_ff;
  assign cc.onoff_rd      = onoff_ff;
  assign cc.cfg_rd        = cfg_ff;
  assign cc.run           = run_ff;
  assign cc.margin        = op_ff[OP_MARGIN_LSB+1:OP_MARGIN_LSB];
  assign cc.ignore_faults = (op_ff[OP_FAULT_LSB+1:OP_FAULT_LSB] == FAULT_IGNORE);
  assign cc.soft_off      = soft_ff;
  assign cc.op_rejected   = cc.wr_op && !op_valid;

  a_op_reserved_keep: assert property (@(posedge core_clk) disable iff (reset)
    cc.wr_op && (w_ctrl == 2'b11) |=> $stable(op_ff) && $stable(run_ff))
    else $error("reserved operation byte changed channel state");
  a_bus_ctrl_ignored: assert property (@(posedge core_clk) disable iff (reset)
    cc.wr_op && !cc.wr_onoff && !onoff_ff[ONOFF_USE_BUS_BIT] |=> $stable(run_ff))
    else $error("operation control acted while bus control disabled");
  a_op_turn_on: assert property (@(posedge core_clk) disable iff (reset)
    cc.wr_op && !cc.wr_onoff && onoff_ff[ONOFF_USE_BUS_BIT] && op_valid &&
    (w_ctrl == CTRL_SEQ_ON) |=> run_ff && !soft_ff && (op_ff[1:0] == 2'b00))
    else $error("sequence on not applied");

endmodule // pmbus_channel_slice

// ==== rtl/pmbus_page_protect_operation.sv ====
// PMBus command layer: paging, global page fan-out, write protection, address base
`timescale 1ns/1ps
module pmbus_page_protect_operation
  import pmbus_cmd_pkg::*;
#(
  parameter int         NUM_CH            = 4,
  parameter logic [7:0] CMD_CLEAR_FAULTS  = 8'h03,
  parameter logic [7:0] CMD_STORE_ALL     = 8'h15,
  parameter logic [7:0] CMD_NVM_UNLOCK    = 8'hBD
)(
  input  wire logic              core_clk,
  input  wire logic              reset,
  input  wire logic              wp_pin,
  input  wire logic [3:0]        addr_offset,
  input  wire logic              cmd_valid,
  input  wire logic              cmd_write,
  input  wire logic [7:0]        cmd_code,
  input  wire logic [15:0]       cmd_wdata,
  output logic                   rsp_valid,
  output logic [15:0]            rsp_data,
  output logic                   rsp_ok,
  output logic                   cml_fault,
  output logic [6:0]             bus_address,
  output logic [NUM_CH-1:0]      ch_clear_faults,
  output logic [NUM_CH-1:0]      ch_run,
  output logic [2*NUM_CH-1:0]    ch_margin,
  output logic [NUM_CH-1:0]      ch_ignore_faults,
  output logic [NUM_CH-1:0]      ch_soft_off
);

  // Page decode below indexes channels with two bits
  if (NUM_CH != 4) begin : g_num_ch_check
    $error("only four channels are supported");
  end

  logic [7:0]  page_ff,   nxt_page;
  logic [7:0]  wp_ff,     nxt_wp;
  logic [7:0]  mask_ff,   nxt_mask;
  logic [7:0]  base_ff,   nxt_base;
  logic [15:0] common_ff, nxt_common;
  logic [7:0]  cfg2_ff,   nxt_cfg2;
  logic [7:0]  cfg3_ff,   nxt_cfg3;
  logic        cml_ff,    nxt_cml;
  logic        rsp_v_ff,  nxt_rsp_v;
  logic        rsp_ok_ff, nxt_rsp_ok;
  logic [15:0] rsp_d_ff,  nxt_rsp_d;
  logic [6:0]  addr_ff,   nxt_addr;
  logic [NUM_CH-1:0] clr_ff, nxt_clr;

  logic [7:0]  op_rd_a    [NUM_CH];
  logic [7:0]  onoff_rd_a [NUM_CH];
  logic [15:0] cfg_rd_a   [NUM_CH];
  logic [NUM_CH-1:0] wr_op_v, wr_onoff_v, wr_cfg_v, op_rej_v;

  prot_e       reg_level, pin_level, eff_level;
  logic        is_paged, global_ok, page_is_global, page_ok;
  logic        allow_l1, allow_l2, permit, do_write, do_read, cml_event;
  logic [NUM_CH-1:0] sel;
  logic [1:0]  pidx;
  logic [3:0]  off_clamped;

  // Protection level seen by the write that completes this cycle
  always_comb begin
    case (wp_ff)
      WP_CODE_LEVEL1: reg_level = PROT_L1;
      WP_CODE_LEVEL2: reg_level = PROT_L2;
      default:        reg_level = PROT_NONE;
    endcase
    pin_level = wp_pin ? PROT_L2 : PROT_NONE;
    eff_level = (reg_level > pin_level) ? reg_level : pin_level;
  end

  always_comb begin
    allow_l1 = (cmd_code == CMD_WRITE_PROTECT) || (cmd_code == CMD_PAGE) ||
               (cmd_code == CMD_NVM_UNLOCK) || (cmd_code == CMD_STORE_ALL);
    allow_l2 = allow_l1 || (cmd_code == CMD_OPERATION) ||
               (cmd_code == CMD_GLOBAL_MASK) || (cmd_code == CMD_CLEAR_FAULTS);
    case (eff_level)
      PROT_NONE: permit = 1'b1;
      PROT_L2:   permit = allow_l2;
      PROT_L1:   permit = allow_l1;
      default:   permit = 1'b0;
    endcase
  end

  always_comb begin
    is_paged       = (cmd_code == CMD_OPERATION) || (cmd_code == CMD_ON_OFF_CONFIG) ||
                     (cmd_code == CMD_CHAN_CFG) || (cmd_code == CMD_CLEAR_FAULTS);
    global_ok      = (cmd_code == CMD_CLEAR_FAULTS) || (cmd_code == CMD_OPERATION) ||
                     (cmd_code == CMD_ON_OFF_CONFIG);
    page_is_global = (page_ff == PAGE_GLOBAL);
    page_ok        = (page_ff < 8'(NUM_CH));
    pidx           = page_ff[1:0];
    if (page_is_global) begin
      sel = mask_ff[NUM_CH-1:0];
    end else if (page_ok) begin
      sel = NUM_CH'(1) << pidx;
    end else begin
      sel = '0;
    end
  end

  always_comb begin
    do_write  = 1'b0;
    do_read   = 1'b0;
    cml_event = 1'b0;
    if (cmd_valid && cmd_write) begin
      if (!permit) begin
        cml_event = 1'b1;
      end else if (is_paged && page_is_global && !global_ok) begin
        cml_event = 1'b1;
      end else if (is_paged && !page_is_global && !page_ok) begin
        cml_event = 1'b1;
      end else if ((cmd_code == CMD_WRITE_PROTECT) && (cmd_wdata[7:0] != WP_CODE_NONE) &&
                   (cmd_wdata[7:0] != WP_CODE_LEVEL1) &&
                   (cmd_wdata[7:0] != WP_CODE_LEVEL2)) begin
        cml_event = 1'b1;
      end else begin
        do_write = 1'b1;
      end
    end else if (cmd_valid) begin
      // Reads never consult the protection level
      if (is_paged && !page_ok) begin
        cml_event = 1'b1;
      end else begin
        do_read = 1'b1;
      end
    end
  end

  // Channel strobes; a reserved operation byte reports a fault without effect
  always_comb begin
    wr_op_v    = (do_write && (cmd_code == CMD_OPERATION))     ? sel : '0;
    wr_onoff_v = (do_write && (cmd_code == CMD_ON_OFF_CONFIG)) ? sel : '0;
    wr_cfg_v   = (do_write && (cmd_code == CMD_CHAN_CFG))      ? sel : '0;
    nxt_clr    = (do_write && (cmd_code == CMD_CLEAR_FAULTS))  ? sel : '0;
  end

  always_comb begin
    nxt_page   = page_ff;
    nxt_wp     = wp_ff;
    nxt_mask   = mask_ff;
    nxt_base   = base_ff;
    nxt_common = common_ff;
    nxt_cfg2   = cfg2_ff;
    nxt_cfg3   = cfg3_ff;
    if (do_write) begin
      case (cmd_code)
        CMD_PAGE:          nxt_page   = cmd_wdata[7:0];
        CMD_WRITE_PROTECT: nxt_wp     = cmd_wdata[7:0];
        CMD_GLOBAL_MASK:   nxt_mask   = cmd_wdata[7:0] & MASK_WMASK;
        CMD_ADDR_BASE:     nxt_base   = cmd_wdata[7:0] & ADDR_BASE_WMASK;
        CMD_COMMON_CFG:    nxt_common = cmd_wdata;
        CMD_CHAN_CFG2:     nxt_cfg2   = cmd_wdata[7:0];
        CMD_CHAN_CFG3:     nxt_cfg3   = cmd_wdata[7:0];
        default:           nxt_page   = page_ff;
      endcase
    end
    // A new fault in the same cycle as a clear keeps the flag set
    nxt_cml = (cml_ff && !(do_write && (cmd_code == CMD_CLEAR_FAULTS))) ||
              cml_event || (|op_rej_v);
    off_clamped = (addr_offset > ADDR_OFFSET_MAX) ? ADDR_OFFSET_MAX : addr_offset;
    nxt_addr    = base_ff[6:0] + {3'b000, off_clamped};
  end

  always_comb begin
    nxt_rsp_v  = cmd_valid;
    nxt_rsp_ok = do_write || do_read;
    nxt_rsp_d  = '0;
    if (do_read) begin
      case (cmd_code)
        CMD_PAGE:          nxt_rsp_d = {8'h00, page_ff};
        CMD_OPERATION:     nxt_rsp_d = {8'h00, op_rd_a[pidx]};
        CMD_ON_OFF_CONFIG: nxt_rsp_d = {8'h00, onoff_rd_a[pidx]};
        CMD_CHAN_CFG:      nxt_rsp_d = cfg_rd_a[pidx];
        CMD_WRITE_PROTECT: nxt_rsp_d = {8'h00, wp_ff};
        CMD_GLOBAL_MASK:   nxt_rsp_d = {8'h00, mask_ff};
        CMD_ADDR_BASE:     nxt_rsp_d = {8'h00, base_ff};
        CMD_COMMON_CFG:    nxt_rsp_d = common_ff;
        CMD_CHAN_CFG2:     nxt_rsp_d = {8'h00, cfg2_ff};
        CMD_CHAN_CFG3:     nxt_rsp_d = {8'h00, cfg3_ff};
        default:           nxt_rsp_d = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      page_ff   <= RST_PAGE;
      wp_ff     <= RST_WRITE_PROTECT;
      mask_ff   <= RST_GLOBAL_MASK;
      base_ff   <= RST_ADDR_BASE;
      common_ff <= RST_COMMON_CFG;
      cfg2_ff   <= RST_CHAN_CFG2;
      cfg3_ff   <= RST_CHAN_CFG3;
      cml_ff    <= 1'b0;
      rsp_v_ff  <= 1'b0;
      rsp_ok_ff <= 1'b0;
      rsp_d_ff  <= '0;
      addr_ff   <= RST_ADDR_BASE[6:0];
      clr_ff    <= '0;
    end else begin
      page_ff   <= nxt_page;
      wp_ff     <= nxt_wp;
      mask_ff   <= nxt_mask;
      base_ff   <= nxt_base;
      common_ff <= nxt_common;
      cfg2_ff   <= nxt_cfg2;
      cfg3_ff   <= nxt_cfg3;
      cml_ff    <= nxt_cml;
      rsp_v_ff  <= nxt_rsp_v;
      rsp_ok_ff <= nxt_rsp_ok;
      rsp_d_ff  <= nxt_rsp_d;
      addr_ff   <= nxt_addr;
      clr_ff    <= nxt_clr;
    end
  end

  chan_ctl_if cc [NUM_CH] ();

  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    assign cc[i].wr_op    = wr_op_v[i];
    assign cc[i].wr_onoff = wr_onoff_v[i];
    assign cc[i].wr_cfg   = wr_cfg_v[i];
    assign cc[i].wdata    = cmd_wdata;
    assign op_rd_a[i]     = cc[i].op_rd;
    assign onoff_rd_a[i]  = cc[i].onoff_rd;
    assign cfg_rd_a[i]    = cc[i].cfg_rd;
    assign op_rej_v[i]    = cc[i].op_rejected;
    assign ch_run[i]      = cc[i].run;
    assign ch_margin[2*i+1:2*i] = cc[i].margin;
    assign ch_ignore_faults[i]  = cc[i].ignore_faults;
    assign ch_soft_off[i] = cc[i].soft_off;

    pmbus_channel_slice u_slice (
      .core_clk (core_clk),
      .reset    (reset),
      .cc       (cc[i])
    );
  end

  assign rsp_valid       = rsp_v_ff;
  assign rsp_data        = rsp_d_ff;
  assign rsp_ok          = rsp_ok_ff;
  assign cml_fault       = cml_ff;
  assign bus_address     = addr_ff;
  assign ch_clear_faults = clr_ff;

  a_global_read_cml: assert property (@(posedge core_clk) disable iff (reset)
    cmd_valid && !cmd_write && (cmd_code == CMD_OPERATION) && page_is_global
    |=> cml_ff && rsp_valid && !rsp_ok && (rsp_data == 16'h0000))
    else $error("global-page paged read did not fault");
  a_global_write_drop: assert property (@(posedge core_clk) disable iff (reset)
    cmd_valid && cmd_write && (cmd_code == CMD_CHAN_CFG) && page_is_global
    |-> (wr_cfg_v == '0) ##1 cml_ff)
    else $error("unsupported global-page write not discarded");
  a_global_fanout: assert property (@(posedge core_clk) disable iff (reset)
    cmd_valid && cmd_write && (cmd_code == CMD_OPERATION) && page_is_global &&
    (wp_ff != WP_CODE_LEVEL1)
    |-> (wr_op_v == mask_ff[NUM_CH-1:0]))
    else $error("global operation write did not follow the mask");
  a_level1_blocks_op: assert property (@(posedge core_clk) disable iff (reset)
    cmd_valid && cmd_write && (cmd_code == CMD_OPERATION) && (wp_ff == WP_CODE_LEVEL1)
    |-> (wr_op_v == '0))
    else $error("level 1 protection let an operation write through");
  a_pin_blocks_base: assert property (@(posedge core_clk) disable iff (reset)
    cmd_valid && cmd_write && (cmd_code == CMD_ADDR_BASE) && wp_pin
    |=> $stable(base_ff) ##1 (bus_address == $past(addr_ff, 1)))
    else $error("pin protection let the address base change");
  a_level2_op_passes: assert property (@(posedge core_clk) disable iff (reset)
    cmd_valid && cmd_write && (cmd_code == CMD_OPERATION) && !wp_pin &&
    (wp_ff == WP_CODE_LEVEL2) && !page_is_global && page_ok
    |-> (wr_op_v == sel) && (sel != '0))
    else $error("level 2 blocked an operation write");
  a_mask_upper_zero: assert property (@(posedge core_clk) disable iff (reset)
    cmd_valid && !cmd_write && (cmd_code == CMD_GLOBAL_MASK)
    |=> (rsp_data[7:4] == 4'h0) && rsp_ok)
    else $error("mask upper bits read nonzero");
  a_base_bit7_zero: assert property (@(posedge core_clk) disable iff (reset)
    cmd_valid && cmd_write && permit && (cmd_code == CMD_ADDR_BASE)
    |=> (base_ff == {1'b0, $past(cmd_wdata[6:0])}))
    else $error("address base bit 7 stored");
  a_address_sum: assert property (@(posedge core_clk) disable iff (reset)
    $stable(base_ff) && $stable(addr_offset) && (addr_offset <= 4'h9)
    |=> (bus_address == 7'($past(base_ff[6:0]) + {3'b000, $past(addr_offset)})))
    else $error("bus address is not base plus offset");
  a_read_ignores_wp: assert property (@(posedge core_clk) disable iff (reset)
    cmd_valid && !cmd_write && (cmd_code == CMD_COMMON_CFG) && (wp_ff == WP_CODE_LEVEL1)
    |=> rsp_ok && (rsp_data == common_ff))
    else $error("read refused under protection");

  c_global_op: cover property (@(posedge core_clk) disable iff (reset)
    do_write && (cmd_code == CMD_OPERATION) && page_is_global);
  c_blocked_write: cover property (@(posedge core_clk) disable iff (reset)
    cmd_valid && cmd_write && !permit);
  c_pin_and_level1: cover property (@(posedge core_clk) disable iff (reset)
    cmd_valid && cmd_write && wp_pin && (wp_ff == WP_CODE_LEVEL1));
  c_offset_clamped: cover property (@(posedge core_clk) disable iff (reset)
    addr_offset > ADDR_OFFSET_MAX);
  c_reserved_op: cover property (@(posedge core_clk) disable iff (reset)
    |op_rej_v);

  // Strap values above nine must not move the address past the documented window
  a_offset_clamp: assert property (@(posedge core_clk) disable iff (reset)
    (addr_offset > ADDR_OFFSET_MAX)
    |=> (bus_address == 7'($past(base_ff[6:0]) + 7'(ADDR_OFFSET_MAX))))
    else $error("address offset above nine not clamped");

endmodule // pmbus_page_protect_operation

// ==== tb/pmbus_host_model.sv ====
// Host model: issues one command at a time and collects the answer
`timescale 1ns/1ps
module pmbus_host_model (
  input  wire logic        core_clk,
  output logic             cmd_valid,
  output logic             cmd_write,
  output logic [7:0]       cmd_code,
  output logic [15:0]      cmd_wdata,
  input  wire logic        rsp_valid,
  input  wire logic [15:0] rsp_data,
  input  wire logic        rsp_ok
);
  initial {cmd_valid, cmd_write, cmd_code, cmd_wdata} = '0;
  task automatic xfer(input logic w, input logic [7:0] c, input logic [15:0] d,
                      output logic [17:0] r);
    cmd_valid <= 1'b1;
    cmd_write <= w;
    cmd_code  <= c;
    cmd_wdata <= d;
    @(posedge core_clk);
    // Released lines carry inverted values so nothing stale looks like a request
    cmd_valid <= 1'b0;
    cmd_write <= ~w;
    cmd_code  <= ~c;
    cmd_wdata <= ~d;
    #1;
    r = {rsp_valid, rsp_ok, rsp_data};
    @(posedge core_clk);
  endtask
endmodule // pmbus_host_model

// ==== tb/pmbus_page_protect_operation_tb.sv ====
// Bench for paging, write protection, address base and OPERATION decode
`timescale 1ns/1ps
module pmbus_page_protect_operation_tb import pmbus_cmd_pkg::*;;
  logic        core_clk = 1'b0;
  logic        reset = 1'b1;
  logic        wp_pin = 1'b0;
  logic [3:0]  addr_offset = 4'h3;
  logic        cmd_valid, cmd_write, rsp_valid, rsp_ok, cml_fault;
  logic [7:0]  cmd_code, ch_margin;
  logic [15:0] cmd_wdata, rsp_data;
  logic [6:0]  bus_address;
  logic [3:0]  ch_clear_faults, ch_run, ch_ignore_faults, ch_soft_off;
  logic [17:0] r;
  logic [3:0]  clr_seen = 4'h0;
  int          n_mismatch = 0;
  int          checks_done = 0;
  always #2.5 core_clk = ~core_clk;
  pmbus_page_protect_operation u_dut (.core_clk, .reset, .wp_pin, .addr_offset,
    .cmd_valid, .cmd_write, .cmd_code, .cmd_wdata, .rsp_valid, .rsp_data, .rsp_ok,
    .cml_fault, .bus_address, .ch_clear_faults, .ch_run, .ch_margin, .ch_ignore_faults,
    .ch_soft_off);
  pmbus_host_model u_host (.core_clk, .cmd_valid, .cmd_write, .cmd_code, .cmd_wdata,
    .rsp_valid, .rsp_data, .rsp_ok);
  // Clear-faults strobes last one cycle, so collect every channel that saw one
  always @(posedge core_clk) begin
    if (!reset) begin
      clr_seen <= clr_seen | ch_clear_faults;
    end
  end
  task automatic chk(input string n, input logic [17:0] s, input logic [17:0] e);
    checks_done++;
    if (s !== e) begin
      n_mismatch++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic wr(input logic [7:0] c, input logic [15:0] d, input logic ok);
    u_host.xfer(1'b1, c, d, r);
    chk("write", r, {1'b1, ok, 16'h0000});
  endtask
  task automatic rd(input logic [7:0] c, input logic ok, input logic [15:0] e);
    u_host.xfer(1'b0, c, 16'h0000, r);
    chk("read", r, {1'b1, ok, e});
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  initial begin
    #5000;
    n_mismatch++;
    close_out();
  end
  initial begin
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    rd(CMD_COMMON_CFG, 1'b1, 16'h0F7B);
    chk("addr", bus_address, 7'h5F);
    wr(CMD_ADDR_BASE, 16'h00A0, 1'b1);
    rd(CMD_ADDR_BASE, 1'b1, 16'h0020);
    chk("addr", bus_address, 7'h23);
    addr_offset <= 4'hC;
    repeat (2) @(posedge core_clk);
    chk("addr", bus_address, 7'h29);
    addr_offset <= 4'h3;
    wr(CMD_PAGE, 16'h0001, 1'b1);
    wr(CMD_ON_OFF_CONFIG, 16'h001A, 1'b1);
    wr(CMD_OPERATION, 16'h0094, 1'b1);
    chk("on", {ch_run, ch_margin, ch_ignore_faults}, {4'h2, 8'h04, 4'h2});
    wr(CMD_PAGE, 16'h0000, 1'b1);
    rd(CMD_ON_OFF_CONFIG, 1'b1, 16'h0012);
    wr(CMD_OPERATION, 16'h0080, 1'b1);
    chk("run", ch_run, 4'h2);
    wr(CMD_GLOBAL_MASK, 16'h00F5, 1'b1);
    rd(CMD_GLOBAL_MASK, 1'b1, 16'h0005);
    wr(CMD_PAGE, 16'h00FF, 1'b1);
    wr(CMD_ON_OFF_CONFIG, 16'h001A, 1'b1);
    wr(CMD_OPERATION, 16'h00A8, 1'b1);
    chk("glob", {ch_run, ch_margin}, {4'h7, 8'h26});
    rd(CMD_OPERATION, 1'b0, 16'h0000);
    wr(CMD_CHAN_CFG, 16'h0001, 1'b0);
    chk("cml", cml_fault, 1'b1);
    wr(8'h03, 16'h0000, 1'b1);
    wr(CMD_PAGE, 16'h0000, 1'b1);
    chk("cml", cml_fault, 1'b0);
    wr(CMD_WRITE_PROTECT, 16'h0080, 1'b1);
    wr(CMD_OPERATION, 16'h0040, 1'b0);
    wr(CMD_GLOBAL_MASK, 16'h000F, 1'b0);
    rd(CMD_COMMON_CFG, 1'b1, 16'h0F7B);
    rd(CMD_OPERATION, 1'b1, 16'h00A8);
    wr(CMD_WRITE_PROTECT, 16'h0033, 1'b0);
    wr(CMD_WRITE_PROTECT, 16'h0040, 1'b1);
    wr(CMD_ON_OFF_CONFIG, 16'h0018, 1'b0);
    wr(CMD_OPERATION, 16'h0040, 1'b1);
    chk("soft", {ch_run, ch_soft_off}, {4'h6, 4'h1});
    // Channel stays off a while before it is switched back on
    repeat (20) @(posedge core_clk);
    wr(CMD_WRITE_PROTECT, 16'h0000, 1'b1);
    wp_pin <= 1'b1;
    wr(CMD_CHAN_CFG, 16'h0001, 1'b0);
    wr(CMD_ADDR_BASE, 16'h0011, 1'b0);
    rd(CMD_ADDR_BASE, 1'b1, 16'h0020);
    wr(CMD_OPERATION, 16'h0080, 1'b1);
    wr(CMD_WRITE_PROTECT, 16'h0080, 1'b1);
    wr(CMD_OPERATION, 16'h0000, 1'b0);
    chk("run", ch_run, 4'h7);
    wp_pin <= 1'b0;
    wr(CMD_WRITE_PROTECT, 16'h0000, 1'b1);
    wr(8'h03, 16'h0000, 1'b1);
    chk("cml", cml_fault, 1'b0);
    wr(CMD_OPERATION, 16'h00C0, 1'b1);
    @(posedge core_clk);
    chk("rsv", {ch_run, ch_margin[1:0], cml_fault}, {4'h7, 2'h0, 1'b1});
    chk("clr", clr_seen, 4'h5);
    close_out();
  end
endmodule // pmbus_page_protect_operation_tb
